// ---- acs_pkg.sv ----
// shared types and constants of the converter setup and channel scan block
package acs_pkg;

   // ---------------------------------------------------------------
   // register select codes of the serial port
   // ---------------------------------------------------------------
   localparam logic [2:0] ACS_SEL_SETUP_ONE = 3'h1;
   localparam logic [2:0] ACS_SEL_SETUP_TWO = 3'h2;
   localparam logic [2:0] ACS_SEL_TF_BASE   = 3'h4;

   // ---------------------------------------------------------------
   // register layouts, msb first
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [1:0] chan_sel;          // chan_sel_hi, chan_sel_lo
      logic [1:0] modulator_rate;    // modulator_rate_hi, _lo
      logic       clock_rate;
      logic [1:0] decimation_sel;    // decimation_sel_hi, _lo
      logic       fast_filter;
   } acs_setup_one_t;

   typedef struct packed {
      logic       sweep_enable;
      logic [1:0] cal_mode;          // cal_mode_hi, cal_mode_lo
      logic       input_buffer_enable;
      logic       pairing_select;
      logic       burnout_source_enable;
      logic       reserved_bit;
      logic       clock_halving_enable;
   } acs_setup_two_t;

   localparam logic [7:0] ACS_SETUP_ONE_RST = 8'h0A;
   localparam logic [7:0] ACS_SETUP_TWO_RST = 8'h00;

   // ---------------------------------------------------------------
   // calibration modes and converted channels
   // ---------------------------------------------------------------
   localparam logic [1:0] ACS_CAL_NORMAL = 2'h0;
   localparam logic [1:0] ACS_CAL_OFFSET = 2'h1;
   localparam logic [1:0] ACS_CAL_GAIN   = 2'h2;

   typedef enum logic [3:0] {
      ACS_CH_P1   = 4'h0,  // input one against analog_common_input
      ACS_CH_P2   = 4'h1,
      ACS_CH_P3   = 4'h2,
      ACS_CH_P4   = 4'h3,
      ACS_CH_P5   = 4'h4,
      ACS_CH_D12  = 4'h5,  // differential pairs
      ACS_CH_D34  = 4'h6,
      ACS_CH_D56  = 4'h7,
      ACS_CH_OFF  = 4'h8,  // offset_cal_input pair
      ACS_CH_GAIN = 4'h9   // gain_cal_input pair
   } acs_chan_t;

   localparam logic [2:0] ACS_SEQ_PSEUDO_LEN = 3'h5;
   localparam logic [2:0] ACS_SEQ_PAIRING_SELECT_LEN   = 3'h3;
   localparam logic [2:0] ACS_SEQ_CAL_EXTRA  = 3'h2;
   localparam logic [1:0] ACS_TF_SWEEP_CAL   = 2'h3;

   // ---------------------------------------------------------------
   // output data rates in samples per second, modulator code 00
   // ---------------------------------------------------------------
   localparam int ACS_RATE_W = 13;
   localparam logic [ACS_RATE_W-1:0] ACS_RATE_LO [4] =
      '{13'h0014, 13'h0019, 13'h0064, 13'h00C8};  // 20 25 100 200
   localparam logic [ACS_RATE_W-1:0] ACS_RATE_HI [4] =
      '{13'h0032, 13'h003C, 13'h012C, 13'h0258};  // 50 60 300 600

   // ---------------------------------------------------------------
   // what the block presents to the analog side
   // ---------------------------------------------------------------
   typedef struct packed {
      acs_chan_t  chan;
      logic [1:0] tf_index;          // transfer register 1..3
      logic       buffer_on;
      logic       burnout_on;
   } acs_route_t;

   // ---------------------------------------------------------------
   // whole state of the block
   // ---------------------------------------------------------------
   typedef struct packed {
      acs_setup_one_t        one;
      acs_setup_two_t        two;
      logic [2:0]            seq_idx;
      logic                  prescale;
      logic                  mod_tick;
      logic                  restart;
      acs_route_t            route;
      logic [ACS_RATE_W-1:0] rate_sps;
      logic [7:0]            rd_data;
   } acs_state_t;

endpackage

// ---- acs_scan_ctrl.sv ----
// setup registers and channel sequencer of the converter
`timescale 1ns/1ps
`default_nettype none

// How it works
// - sweep on converts channels in fixed order
// - sweep off repeats one selected channel
// - cal code 01 offset pair, 10 gain
// - single cal uses selected channel's transfer register
// - sweep cal appends offset then gain conversion
// - sweep order five pseudo or three pairs
// - sweep cal conversions use third transfer register
// - pairing 0: inputs one-five against six
// - pairing 1: three differential input pairs
// - buffer bit powers input buffers
// - burnout bit connects sources to selected channel
// - halving bit divides internal clock by two
// - clock bit 0 rates 20..200, doubling
// - clock bit 1 rates 50..600, up 4800
// - channel select ignored while sweeping
// - active control change restarts filter
module acs_scan_ctrl
   import acs_pkg::*;
(
   // clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  rst_n,
   input  wire logic                  soft_reset,
   // register port from the serial interface
   input  wire logic                  reg_wr,
   input  wire logic [2:0]            reg_wr_sel,
   input  wire logic [7:0]            reg_wr_data,
   input  wire logic [2:0]            reg_rd_sel,
   output logic      [7:0]            reg_rd_data,
   // converter handshake
   input  wire logic                  conv_done,
   output logic                       filter_restart,
   output logic                       mod_clk_tick,
   // analog routing and rate
   output acs_route_t                 route,
   output logic      [ACS_RATE_W-1:0] rate_sps
);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [1:0] tf_of(input acs_chan_t c);
      case (c)
         ACS_CH_P1, ACS_CH_P2, ACS_CH_D12: tf_of = 2'h1;
         ACS_CH_P3, ACS_CH_P4, ACS_CH_D34: tf_of = 2'h2;
         default:                          tf_of = 2'h3;
      endcase
   endfunction

   // signal channel picked by index and pairing
   function automatic acs_chan_t sig_chan(input logic pair,
                                          input logic [2:0] idx);
      if (pair) begin
         case (idx)
            3'h0:    sig_chan = ACS_CH_D12;
            3'h1:    sig_chan = ACS_CH_D34;
            default: sig_chan = ACS_CH_D56;
         endcase
      end else begin
         case (idx)
            3'h0:    sig_chan = ACS_CH_P1;
            3'h1:    sig_chan = ACS_CH_P2;
            3'h2:    sig_chan = ACS_CH_P3;
            3'h3:    sig_chan = ACS_CH_P4;
            default: sig_chan = ACS_CH_P5;
         endcase
      end
   endfunction

   // number of signal channels in the sweep for a pairing mode
   function automatic logic [2:0] sig_len_of(input logic pair);
      sig_len_of = pair ? ACS_SEQ_PAIRING_SELECT_LEN : ACS_SEQ_PSEUDO_LEN;
   endfunction

   acs_state_t st_q;
   acs_state_t st_d;

   logic       cal_on;
   logic [2:0] sig_len;
   logic [2:0] seq_len;
   logic [7:0] changed;
   logic       ctl_hit;
   acs_chan_t  sel_chan;
   logic       wr_one;
   logic       wr_two;
   logic [2:0] sweep_sig;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      st_d     = st_q;
      sel_chan = ACS_CH_P1;
      wr_one   = reg_wr && (reg_wr_sel == ACS_SEL_SETUP_ONE);
      wr_two   = reg_wr && (reg_wr_sel == ACS_SEL_SETUP_TWO);
      // reserved code 11 is treated as normal; host must avoid it
      cal_on  = (st_q.two.cal_mode == ACS_CAL_OFFSET) ||
                (st_q.two.cal_mode == ACS_CAL_GAIN);
      sig_len = sig_len_of(st_q.two.pairing_select);
      seq_len = cal_on ? sig_len + ACS_SEQ_CAL_EXTRA : sig_len;
      changed = 8'h00;
      ctl_hit = 1'b0;

      // register writes; reserved bit is stored as written
      if (wr_one) begin
         changed = reg_wr_data ^ st_q.one;
         if (st_q.two.sweep_enable)
            changed[7:6] = 2'b00;
         st_d.one = acs_setup_one_t'(reg_wr_data);
      end
      if (wr_two) begin
         changed = reg_wr_data ^ st_q.two;
         st_d.two = acs_setup_two_t'(reg_wr_data);
         st_d.seq_idx = 3'h0;
      end
      // only the transfer register feeding the live conversion counts
      if (reg_wr && reg_wr_sel[2] &&
          reg_wr_sel[1:0] + 2'h1 == st_q.route.tf_index)
         ctl_hit = 1'b1;
      st_d.restart = ctl_hit || (changed != 8'h00);

      // soft reset lands before routing so the route falls back at once
      if (soft_reset) begin
         st_d.one      = acs_setup_one_t'(ACS_SETUP_ONE_RST);
         st_d.two      = acs_setup_two_t'(ACS_SETUP_TWO_RST);
         st_d.seq_idx  = 3'h0;
         st_d.restart  = 1'b1;
      end

      // sequencer advance; a restart or a same-value setup two write wins,
      // so a rewrite always starts the sweep from its first entry
      if (st_q.two.sweep_enable && conv_done && !st_d.restart &&
          !wr_two) begin
         if (st_q.seq_idx + 3'h1 >= seq_len)
            st_d.seq_idx = 3'h0;
         else
            st_d.seq_idx = st_q.seq_idx + 3'h1;
      end

      // routing, from the state as it will stand
      sweep_sig = sig_len_of(st_d.two.pairing_select);
      if (st_d.two.sweep_enable) begin
         if (st_d.seq_idx < sweep_sig) begin
            st_d.route.chan = sig_chan(st_d.two.pairing_select,
                                       st_d.seq_idx);
            st_d.route.tf_index = tf_of(st_d.route.chan);
         end else begin
            // offset always before gain
            st_d.route.chan = (st_d.seq_idx == sweep_sig) ?
                              ACS_CH_OFF : ACS_CH_GAIN;
            st_d.route.tf_index = ACS_TF_SWEEP_CAL;
         end
      end else begin
         sel_chan = sig_chan(st_d.two.pairing_select,
                             {1'b0, st_d.one.chan_sel});
         st_d.route.tf_index = tf_of(sel_chan);
         case (st_d.two.cal_mode)
            ACS_CAL_OFFSET: st_d.route.chan = ACS_CH_OFF;
            ACS_CAL_GAIN:   st_d.route.chan = ACS_CH_GAIN;
            default:        st_d.route.chan = sel_chan;
         endcase
      end
      if (!st_d.two.sweep_enable)
         st_d.seq_idx = 3'h0;
      st_d.route.buffer_on  = st_d.two.input_buffer_enable;
      st_d.route.burnout_on = st_d.two.burnout_source_enable;

      // prescaler: tick every edge, or every second edge when halved
      st_d.prescale = ~st_q.prescale;
      st_d.mod_tick = st_d.two.clock_halving_enable ?
                      st_q.prescale : 1'b1;

      // data rate table, each modulator step doubles the rate
      st_d.rate_sps = (st_d.one.clock_rate ?
         ACS_RATE_HI[st_d.one.decimation_sel] :
         ACS_RATE_LO[st_d.one.decimation_sel]) <<
         st_d.one.modulator_rate;

      case (reg_rd_sel)
         ACS_SEL_SETUP_ONE: st_d.rd_data = st_q.one;
         ACS_SEL_SETUP_TWO: st_d.rd_data = st_q.two;
         default:           st_d.rd_data = 8'h00;
      endcase
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_q          <= '0;
         st_q.one      <= acs_setup_one_t'(ACS_SETUP_ONE_RST);
         st_q.two      <= acs_setup_two_t'(ACS_SETUP_TWO_RST);
         st_q.route    <= '{chan: ACS_CH_P1, tf_index: 2'h1,
                            buffer_on: 1'b0, burnout_on: 1'b0};
         // reset rate follows the reset clock and filter bits
         st_q.rate_sps <= ACS_RATE_HI[1];
      end else begin
         st_q <= st_d;
      end
   end

   // every output is a field of the state register, no logic after it
   assign reg_rd_data    = st_q.rd_data;
   assign filter_restart = st_q.restart;
   assign mod_clk_tick   = st_q.mod_tick;
   assign route          = st_q.route;
   assign rate_sps       = st_q.rate_sps;

endmodule // acs_scan_ctrl

`default_nettype wire

// ---- acs_scan_ctrl_props.sv ----
// port checker of the converter setup and scan block
`timescale 1ns/1ps
`default_nettype none
module acs_scan_ctrl_props
   import acs_pkg::*;
(
   // clock and reset
   input wire logic                  clk_sys,
   input wire logic                  rst_n,
   input wire logic                  soft_reset,
   // register writes
   input wire logic                  reg_wr,
   input wire logic [2:0]            reg_wr_sel,
   input wire logic [7:0]            reg_wr_data,
   // watched outputs
   input wire logic                  filter_restart,
   input wire logic                  mod_clk_tick,
   input wire acs_route_t            route,
   input wire logic [ACS_RATE_W-1:0] rate_sps
);
   localparam logic [12:0] RATE_TAB [8] = '{13'h0014, 13'h0019, 13'h0064,
      13'h00C8, 13'h0032, 13'h003C, 13'h012C, 13'h0258};
   logic [7:0]  one_q;
   logic        sweep_q;
   logic [12:0] rate_x;
   logic        wr1;
   logic        wr2;
   logic        req;
   assign wr1    = reg_wr && !soft_reset && reg_wr_sel == ACS_SEL_SETUP_ONE;
   assign wr2    = reg_wr && !soft_reset && reg_wr_sel == ACS_SEL_SETUP_TWO;
   assign req    = reg_wr | soft_reset;
   assign rate_x = RATE_TAB[reg_wr_data[3:1]] << reg_wr_data[5:4];
   // shadows only see writes, so a soft reset must clear them too
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         one_q   <= ACS_SETUP_ONE_RST;
         sweep_q <= 1'b0;
      end else if (soft_reset) begin
         one_q   <= ACS_SETUP_ONE_RST;
         sweep_q <= 1'b0;
      end else begin
         if (wr1) one_q <= reg_wr_data;
         if (wr2) sweep_q <= reg_wr_data[7];
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   chk_restart_cause: assert property (filter_restart |-> $past(req))
      else $error("restart without a write");
   chk_restart_active: assert property (wr1 && !sweep_q &&
      reg_wr_data != one_q |=> filter_restart) else $error("no restart");
   chk_chan_ignored: assert property (wr1 && sweep_q &&
      reg_wr_data[5:0] == one_q[5:0] |=> !filter_restart)
      else $error("restart on channel select while sweeping");
   chk_rate_table: assert property (wr1 |=>
      rate_sps == $past(rate_x)) else $error("wrong data rate");
   chk_sweep_start: assert property (wr2 && reg_wr_data[7] |=>
      route.chan == ($past(reg_wr_data[3]) ? ACS_CH_D12 : ACS_CH_P1))
      else $error("sweep does not start at first entry");
   chk_cal_single: assert property (wr2 && reg_wr_data[7:5] == 3'h1
      |=> route.chan == ACS_CH_OFF) else $error("offset pair not routed");
   chk_sweep_tf: assert property (sweep_q && route.chan inside
      {ACS_CH_OFF, ACS_CH_GAIN} |-> route.tf_index == 2'h3)
      else $error("sweep calibration not on third transfer register");
   chk_buf_burn: assert property (wr2 |=>
      route.buffer_on == $past(reg_wr_data[4]) &&
      route.burnout_on == $past(reg_wr_data[2]))
      else $error("buffer or burnout enable wrong");
   chk_halve_tick: assert property (wr2 && reg_wr_data[0] ##1
      (!req) [*3] |-> mod_clk_tick != $past(mod_clk_tick))
      else $error("tick not halved");
   chk_tf_active: assert property (reg_wr && !soft_reset &&
      reg_wr_sel == ACS_SEL_TF_BASE && route.tf_index == 2'h1
      |=> filter_restart) else $error("no restart on live transfer write");
   chk_tf_inactive: assert property (reg_wr && !soft_reset &&
      reg_wr_sel == ACS_SEL_TF_BASE + 3'h1 && route.tf_index == 2'h1
      |=> !filter_restart) else $error("restart on idle transfer write");
   chk_soft_reset: assert property (soft_reset |=> filter_restart &&
      route.chan == ACS_CH_P1) else $error("soft reset not applied");
   cover property (wr2 && reg_wr_data[7]);
   cover property (sweep_q && route.chan == ACS_CH_GAIN);
   cover property (wr1 && sweep_q);
endmodule // acs_scan_ctrl_props
`default_nettype wire

// ---- acs_host_model.sv ----
// host side model that programs the setup registers
`timescale 1ns/1ps
`default_nettype none
module acs_host_model
   import acs_pkg::*;
(
   // clock and read data
   input  wire logic       clk_sys,
   input  wire logic [7:0] reg_rd_data,
   // requests to the block
   output var  logic       soft_reset,
   output var  logic       reg_wr,
   output var  logic [2:0] reg_wr_sel,
   output var  logic [7:0] reg_wr_data,
   output var  logic [2:0] reg_rd_sel,
   output var  logic       conv_done
);
   initial begin
      {soft_reset, reg_wr, conv_done} = 3'h0;
      {reg_wr_sel, reg_rd_sel} = 6'h00;
      reg_wr_data = 8'h00;
   end
   task automatic wr(input logic [2:0] s, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (s == ACS_SEL_SETUP_TWO) begin
         v[1] = 1'b0;
         if (v[6:5] == 2'h3) v[6:5] = ACS_CAL_NORMAL;
      end
      @(posedge clk_sys);
      reg_wr      <= 1'b1;
      reg_wr_sel  <= s;
      reg_wr_data <= v;
      @(posedge clk_sys);
      reg_wr      <= 1'b0;
      // released data no longer holds the written value
      reg_wr_data <= ~v;
      @(negedge clk_sys);
   endtask
   // one-cycle soft reset (s=1) or end of conversion (s=0)
   task automatic strobe(input logic s);
      @(posedge clk_sys);
      soft_reset <= s;
      conv_done  <= !s;
      @(posedge clk_sys);
      soft_reset <= 1'b0;
      conv_done  <= 1'b0;
      @(negedge clk_sys);
   endtask
   task automatic rd(input logic [2:0] s, output logic [7:0] d);
      @(posedge clk_sys);
      reg_rd_sel <= s;
      @(posedge clk_sys);
      @(negedge clk_sys);
      d = reg_rd_data;
   endtask
endmodule // acs_host_model
`default_nettype wire

// ---- test_acs_scan_ctrl.sv ----
// self-checking bench of the converter setup and scan block
`timescale 1ns/1ps
`default_nettype none
module test_acs_scan_ctrl;
   import acs_pkg::*;
   logic                  clk_sys = 1'b0;
   logic                  rst_n = 1'b0;
   logic                  soft_reset;
   logic                  reg_wr;
   logic                  conv_done;
   logic [2:0]            reg_wr_sel;
   logic [2:0]            reg_rd_sel;
   logic [7:0]            reg_wr_data;
   logic [7:0]            reg_rd_data;
   logic                  filter_restart;
   logic                  mod_clk_tick;
   acs_route_t            route;
   logic [ACS_RATE_W-1:0] rate_sps;
   int                    err_total = 0;
   int                    check_count = 0;
   always #20 clk_sys = ~clk_sys;
   acs_scan_ctrl i_acs_scan_ctrl (.clk_sys(clk_sys), .rst_n(rst_n),
      .soft_reset(soft_reset), .reg_wr(reg_wr), .reg_wr_sel(reg_wr_sel),
      .reg_wr_data(reg_wr_data), .reg_rd_sel(reg_rd_sel),
      .reg_rd_data(reg_rd_data), .conv_done(conv_done),
      .filter_restart(filter_restart), .mod_clk_tick(mod_clk_tick),
      .route(route), .rate_sps(rate_sps));
   acs_host_model i_acs_host_model (.clk_sys(clk_sys),
      .reg_rd_data(reg_rd_data), .soft_reset(soft_reset), .reg_wr(reg_wr),
      .reg_wr_sel(reg_wr_sel), .reg_wr_data(reg_wr_data),
      .reg_rd_sel(reg_rd_sel), .conv_done(conv_done));
   task automatic chk(input string nm, input logic [12:0] e,
                      input logic [12:0] g);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rdc(input logic [2:0] s, input logic [7:0] e);
      logic [7:0] d;
      i_acs_host_model.rd(s, d);
      chk("read", {5'h00, e}, {5'h00, d});
   endtask
   task automatic rt(input logic [3:0] c, input logic [1:0] t);
      chk("chan", {9'h000, c}, {9'h000, route.chan});
      chk("tf", {11'h000, t}, {11'h000, route.tf_index});
   endtask
   task automatic single(input logic [7:0] d2);
      i_acs_host_model.wr(ACS_SEL_SETUP_TWO, d2);
      for (int a = 0; a < 4; a++) begin
         logic [1:0] m;
         m = (d2[3] && a == 3) ? 2'h2 : a[1:0];
         i_acs_host_model.wr(ACS_SEL_SETUP_ONE, {a[1:0], 6'h0A});
         i_acs_host_model.strobe(1'b0);
         rt(d2[6:5] != 2'h0 ? 4'h7 + {2'h0, d2[6:5]} :
            (d2[3] ? 4'h5 + {2'h0, m} : {2'h0, m}),
            d2[3] ? m + 2'h1 : {1'b0, m[1]} + 2'h1);
      end
   endtask
   task automatic sweep(input logic [7:0] d2);
      int len;
      int tot;
      len = d2[3] ? 3 : 5;
      tot = len + ((d2[6:5] != 2'h0) ? 2 : 0);
      i_acs_host_model.wr(ACS_SEL_SETUP_TWO, d2);
      for (int i = 0; i <= tot; i++) begin
         int k;
         k = i % tot;
         if (k < len) rt(d2[3] ? 4'h5 + k[3:0] : k[3:0],
            d2[3] ? k[1:0] + 2'h1 : k[2:1] + 2'h1);
         else rt(k == len ? 4'h8 : 4'h9, 2'h3);
         i_acs_host_model.strobe(1'b0);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (100000) @(posedge clk_sys);
      err_total++;
      results();
   end
   initial begin
      logic [12:0] lo [4] = '{13'h0014, 13'h0019, 13'h0064, 13'h00C8};
      logic [12:0] hi [4] = '{13'h0032, 13'h003C, 13'h012C, 13'h0258};
      logic        t0;
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      rdc(ACS_SEL_SETUP_ONE, 8'h0A);
      rdc(ACS_SEL_SETUP_TWO, 8'h00);
      rdc(3'h0, 8'h00);
      chk("rate", 13'h003C, rate_sps);
      $display("reset test done");
      for (int i = 0; i < 32; i++) begin
         i_acs_host_model.wr(ACS_SEL_SETUP_ONE, {2'h0, i[4:0], 1'b0});
         chk("rate", (i[2] ? hi[i[1:0]] : lo[i[1:0]]) << i[4:3],
             rate_sps);
      end
      $display("rate test done");
      single(8'h00);
      single(8'h08);
      single(8'h20);
      single(8'h48);
      $display("single channel test done");
      sweep(8'h80);
      sweep(8'hA0);
      sweep(8'h88);
      sweep(8'hC8);
      i_acs_host_model.wr(ACS_SEL_SETUP_ONE, 8'h0A);
      chk("restart", 13'h0000, {12'h000, filter_restart});
      // the last sweep stopped on the second pair; select must not move it
      rt(4'h6, 2'h2);
      i_acs_host_model.wr(ACS_SEL_SETUP_ONE, 8'h0E);
      chk("restart", 13'h0001, {12'h000, filter_restart});
      $display("sweep test done");
      i_acs_host_model.wr(ACS_SEL_SETUP_TWO, 8'h14);
      rdc(ACS_SEL_SETUP_TWO, 8'h14);
      chk("buffer", 13'h0001, {12'h000, route.buffer_on});
      chk("burnout", 13'h0001, {12'h000, route.burnout_on});
      i_acs_host_model.wr(ACS_SEL_SETUP_TWO, 8'h00);
      repeat (2) @(negedge clk_sys);
      chk("tick", 13'h0001, {12'h000, mod_clk_tick});
      i_acs_host_model.wr(ACS_SEL_SETUP_TWO, 8'h01);
      repeat (2) @(negedge clk_sys);
      t0 = mod_clk_tick;
      @(negedge clk_sys);
      chk("tick", {12'h000, ~t0}, {12'h000, mod_clk_tick});
      $display("enable bits test done");
      i_acs_host_model.strobe(1'b1);
      rdc(ACS_SEL_SETUP_ONE, 8'h0A);
      rdc(ACS_SEL_SETUP_TWO, 8'h00);
      rt(4'h0, 2'h1);
      $display("soft reset test done");
      i_acs_host_model.wr(ACS_SEL_TF_BASE, 8'h10);
      chk("restart", 13'h0001, {12'h000, filter_restart});
      i_acs_host_model.wr(ACS_SEL_TF_BASE + 3'h1, 8'h10);
      chk("restart", 13'h0000, {12'h000, filter_restart});
      $display("transfer register test done");
      results();
   end
endmodule // test_acs_scan_ctrl
bind acs_scan_ctrl acs_scan_ctrl_props i_acs_scan_ctrl_props (
   .clk_sys(clk_sys), .rst_n(rst_n), .soft_reset(soft_reset),
   .reg_wr(reg_wr), .reg_wr_sel(reg_wr_sel), .reg_wr_data(reg_wr_data),
   .filter_restart(filter_restart), .mod_clk_tick(mod_clk_tick),
   .route(route), .rate_sps(rate_sps));
`default_nettype wire
